//--- dv/aafu_conv_model.sv
// conversion core stand-in: one result strobe a fixed latency after each trigger
// assumes trig is a one-cycle pulse synchronous to clk
module aafu_conv_model #(
  parameter int LAT = 3
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        trig,
  input  wire logic [11:0] data,
  output logic             valid,
  output logic [11:0]      result
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      valid <= 1'b0;
      result <= 12'h000;
    end else begin
      if (trig) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      valid <= (cnt == 1);
      // between strobes the bus toggles so a stale value never looks valid
      result <= (cnt == 1) ? data : ~result;
    end
  end
endmodule

//--- dv/aafu_top_sva.sv
// port assertions for the accumulate/filter unit
// assumes a bind onto aafu_top; one clock MCLK, reset RESET
module aafu_top_sva #(
  parameter int ACC_W   = 18,
  parameter int CNT_W   = 8,
  parameter int SHIFT_W = 3
) (
  input wire logic               MCLK,
  input wire logic               RESET,
  input wire logic [2:0]         COMPUTATION_MODE_SELECT,
  input wire logic               DOUBLE_SAMPLE_ENABLE,
  input wire logic [SHIFT_W-1:0] SHIFT_AMOUNT,
  input wire logic [CNT_W-1:0]   REPEAT_TARGET,
  input wire logic               ACCUMULATOR_CLEAR_SET,
  input wire logic               CONVERSION_VALID,
  input wire logic               ACCUMULATOR_CLEAR_REQUEST,
  input wire logic [ACC_W-1:0]   ACCUMULATOR_VALUE,
  input wire logic [CNT_W-1:0]   SAMPLE_COUNTER,
  input wire logic [ACC_W-1:0]   FILTERED_RESULT,
  input wire logic               THRESHOLD_TEST_STROBE,
  input wire logic               RETRIGGER
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  clr_ends_a: assert property (ACCUMULATOR_CLEAR_REQUEST |-> ##[1:10] !ACCUMULATOR_CLEAR_REQUEST)
    else $error("clear request stuck");
  clr_zero_a: assert property ($fell(ACCUMULATOR_CLEAR_REQUEST) |-> $past(ACCUMULATOR_VALUE) == 18'h00000
    && $past(SAMPLE_COUNTER) == 8'h00) else $error("clear left state");
  cnt_step_a: assert property ($changed(SAMPLE_COUNTER) |-> SAMPLE_COUNTER == 8'h00
    || SAMPLE_COUNTER == $past(SAMPLE_COUNTER) + 8'h01) else $error("counter jump");
  basic_hold_a: assert property ((COMPUTATION_MODE_SELECT == 3'h0 && !ACCUMULATOR_CLEAR_SET)[*4]
    |=> $stable(ACCUMULATOR_VALUE) && $stable(SAMPLE_COUNTER)) else $error("basic mode moved");
  test_each_a: assert property (COMPUTATION_MODE_SELECT inside {3'h0, 3'h1} && CONVERSION_VALID
    && !DOUBLE_SAMPLE_ENABLE && !ACCUMULATOR_CLEAR_SET && !$past(ACCUMULATOR_CLEAR_SET)
    && !ACCUMULATOR_CLEAR_REQUEST |-> ##2 THRESHOLD_TEST_STROBE) else $error("test missed");
  test_gate_a: assert property (THRESHOLD_TEST_STROBE
    && $past(COMPUTATION_MODE_SELECT, 2) inside {3'h2, 3'h3, 3'h4}
    |-> SAMPLE_COUNTER >= REPEAT_TARGET) else $error("early test");
  retrig_a: assert property (RETRIGGER |-> $past(COMPUTATION_MODE_SELECT, 2) == 3'h3
    && SAMPLE_COUNTER < REPEAT_TARGET) else $error("bad retrigger");
  filt_load_a: assert property ($past(COMPUTATION_MODE_SELECT, 2) inside {3'h1, 3'h2, 3'h3, 3'h4}
    |-> FILTERED_RESULT == ($past(ACCUMULATOR_VALUE) >> $past(SHIFT_AMOUNT, 2))) else $error("filtered value");
endmodule

bind aafu_top aafu_top_sva #(
  .ACC_W   (ACC_W),
  .CNT_W   (CNT_W),
  .SHIFT_W (SHIFT_W)
) u_sva (
  .MCLK                      (MCLK),
  .RESET                     (RESET),
  .COMPUTATION_MODE_SELECT   (COMPUTATION_MODE_SELECT),
  .DOUBLE_SAMPLE_ENABLE      (DOUBLE_SAMPLE_ENABLE),
  .SHIFT_AMOUNT              (SHIFT_AMOUNT),
  .REPEAT_TARGET             (REPEAT_TARGET),
  .ACCUMULATOR_CLEAR_SET     (ACCUMULATOR_CLEAR_SET),
  .CONVERSION_VALID          (CONVERSION_VALID),
  .ACCUMULATOR_CLEAR_REQUEST (ACCUMULATOR_CLEAR_REQUEST),
  .ACCUMULATOR_VALUE         (ACCUMULATOR_VALUE),
  .SAMPLE_COUNTER            (SAMPLE_COUNTER),
  .FILTERED_RESULT           (FILTERED_RESULT),
  .THRESHOLD_TEST_STROBE     (THRESHOLD_TEST_STROBE),
  .RETRIGGER                 (RETRIGGER)
);

//--- dv/aafu_top_tb_top.sv
// self-checking bench for the accumulate/filter unit
// assumes aafu_conv_model answers start and retrigger pulses
module aafu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, reset = 1'b1, clr_set = 1'b0, start = 1'b0, double_sample_enable = 1'b0;
  logic        valid, retrig, clr_req, ovf, strobe;
  logic [2:0]  mode = 3'h0, shift = 3'h0;
  logic [7:0]  target = 8'h00, cnt;
  logic [11:0] data = 12'h000, result, prev;
  logic [17:0] acc, filt;
  int          n_fail, cmp_count, n_strobe, s0;

  aafu_conv_model u_conv (.clk(mclk), .rst(reset), .trig(start | retrig), .data(data), .valid(valid),
    .result(result));
  aafu_top u_dut (.MCLK(mclk), .RESET(reset), .COMPUTATION_MODE_SELECT(mode), .DOUBLE_SAMPLE_ENABLE(double_sample_enable),
    .SHIFT_AMOUNT(shift), .REPEAT_TARGET(target), .ACCUMULATOR_CLEAR_SET(clr_set), .START_TRIGGER(start),
    .CONVERSION_VALID(valid), .CONVERSION_RESULT(result), .ACCUMULATOR_CLEAR_REQUEST(clr_req),
    .ACCUMULATOR_VALUE(acc), .SAMPLE_COUNTER(cnt), .ACCUMULATOR_OVERFLOW_FLAG(ovf), .FILTERED_RESULT(filt),
    .PREVIOUS_SAMPLE(prev), .THRESHOLD_TEST_STROBE(strobe), .RETRIGGER(retrig));

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (strobe === 1'b1) n_strobe++;

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic clear;
    clr_set <= 1'b1;
    cyc(1);
    clr_set <= 1'b0;
    cyc(2);
    chk(clr_req, 1'b1);
    cyc(10);
    chk(clr_req, 1'b0);
    chk(acc, 18'h0);
    chk(cnt, 8'h00);
    chk(ovf, 1'b0);
    s0 = n_strobe;
  endtask
  task automatic setup(input logic [2:0] m, input logic [2:0] s, input logic [7:0] t, input logic d);
    mode <= m;
    shift <= s;
    target <= t;
    double_sample_enable <= d;
    clear();
  endtask
  task automatic conv(input logic [11:0] v);
    data <= v;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(7);
  endtask

  task automatic t_accum;
    setup(3'h1, 3'h2, 8'h00, 1'b0);
    conv(12'h005);
    conv(12'h007);
    chk(acc, 18'h0000c);
    chk(cnt, 8'h02);
    chk(filt, 18'h00003);
    chk(18'(n_strobe - s0), 18'h2);
  endtask
  task automatic t_double_sample_enable;
    setup(3'h1, 3'h0, 8'h00, 1'b1);
    conv(12'h00a);
    conv(12'h01e);
    chk(acc, 18'h00014);
    chk(prev, 12'h00a);
    chk(cnt, 8'h01);
    chk(18'(n_strobe - s0), 18'h1);
    conv(12'h010);
    conv(12'h008);
    chk(acc, 18'h0000c);
    chk(cnt, 8'h02);
  endtask
  task automatic t_basic;
    setup(3'h1, 3'h0, 8'h00, 1'b0);
    conv(12'h009);
    mode <= 3'h0;
    s0 = n_strobe;
    conv(12'h004);
    conv(12'h004);
    chk(acc, 18'h00009);
    chk(cnt, 8'h01);
    chk(18'(n_strobe - s0), 18'h2);
  endtask
  task automatic t_avg;
    setup(3'h2, 3'h2, 8'h04, 1'b0);
    repeat (4) conv(12'h008);
    chk(filt, 18'h00008);
    chk(18'(n_strobe - s0), 18'h1);
    conv(12'h008);
    chk(acc, 18'h00008);
    chk(cnt, 8'h01);
  endtask
  task automatic t_burst;
    setup(3'h3, 3'h2, 8'h04, 1'b0);
    conv(12'h006);
    cyc(40);
    chk(acc, 18'h00018);
    chk(cnt, 8'h04);
    chk(18'(n_strobe - s0), 18'h1);
    clear();
  endtask
  task automatic t_lpf;
    setup(3'h4, 3'h1, 8'h02, 1'b0);
    conv(12'h064);
    conv(12'h064);
    chk(acc, 18'h00096);
    chk(filt, 18'h0004b);
    chk(18'(n_strobe - s0), 18'h1);
  endtask
  task automatic t_ovf;
    setup(3'h1, 3'h0, 8'h00, 1'b0);
    repeat (64) conv(12'hfff);
    chk(ovf, 1'b0);
    conv(12'hfff);
    chk(ovf, 1'b1);
    repeat (190) conv(12'hfff);
    chk(cnt, 8'hff);
    conv(12'hfff);
    chk(cnt, 8'hff);
    clear();
  endtask
  task automatic t_prio;
    setup(3'h1, 3'h0, 8'h00, 1'b0);
    data <= 12'h003;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(3);
    clr_set <= 1'b1;
    cyc(1);
    clr_set <= 1'b0;
    cyc(12);
    chk(acc, 18'h0);
    chk(cnt, 8'h00);
  endtask

  initial begin
    cyc(6);
    reset <= 1'b0;
    cyc(1);
    t_accum();
    t_double_sample_enable();
    t_basic();
    t_avg();
    t_burst();
    t_lpf();
    t_ovf();
    t_prio();
    stop_test();
  end
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule

//--- rtl/aafu_clear_seq.sv
// multi-cycle clear sequencer: holds clear active then one wait state before idle
// assumes the request is a level from software, cleared by aafu_top once clearing ends
module aafu_clear_seq
  import aafu_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req_set,
  output logic      clearing,
  output logic      busy
);
  aafu_clr_state_type state_reg;
  aafu_clr_state_type state_next;
  logic [2:0]         cnt_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AAFU_IDLE:  if (req_set) state_next = AAFU_CLEAR;
      AAFU_CLEAR: if (cnt_reg == `AAFU_CLR_CYCLES - 3'h1) state_next = AAFU_WAIT;
      AAFU_WAIT:  state_next = AAFU_IDLE;
      default:    state_next = AAFU_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= AAFU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
    end else if (state_reg == AAFU_CLEAR) begin
      cnt_reg <= cnt_reg + 3'h1;
    end else begin
      cnt_reg <= 3'h0;
    end
  end

  assign clearing = (state_reg == AAFU_CLEAR) || (req_set && state_reg == AAFU_IDLE);
  assign busy     = (state_reg != AAFU_IDLE) || req_set;
endmodule

//--- rtl/aafu_map.svh
// constants for the accumulate/filter unit: widths, reset values, mode codes, timing
// assumes inclusion by the package and the design modules only
`ifndef AAFU_MAP_SVH
`define AAFU_MAP_SVH
`define AAFU_ACC_W        18
`define AAFU_RES_W        12
`define AAFU_CNT_W        8
`define AAFU_SHIFT_W      3
`define AAFU_MODE_W       3
`define AAFU_CNT_SAT      8'hff
`define AAFU_ACC_RST      18'h00000
`define AAFU_CNT_RST      8'h00
`define AAFU_MODE_BASIC   3'h0
`define AAFU_MODE_ACCUM   3'h1
`define AAFU_MODE_AVG     3'h2
`define AAFU_MODE_BURST   3'h3
`define AAFU_MODE_LPF     3'h4
`define AAFU_CLR_CYCLES   3'h5
`endif

//--- rtl/aafu_pkg.sv
// types for the accumulate/filter unit
// assumes aafu_map.svh is on the include path
`include "aafu_map.svh"
package aafu_pkg;
  typedef enum logic [2:0] {
    AAFU_BASIC = 3'b000,
    AAFU_ACCUM = 3'b001,
    AAFU_AVG   = 3'b010,
    AAFU_BURST = 3'b011,
    AAFU_LPF   = 3'b100
  } aafu_mode_type;

  typedef enum logic [1:0] {
    AAFU_IDLE   = 2'b00,
    AAFU_CLEAR  = 2'b01,
    AAFU_WAIT   = 2'b10
  } aafu_clr_state_type;

  typedef struct packed {
    logic                    valid;
    logic                    signed_neg;
    logic [`AAFU_ACC_W-1:0]  magnitude;
  } aafu_sample_type;
endpackage

//--- rtl/aafu_sample_select.sv
// forms the signed sample term from one or two conversion results
// assumes results arrive with a one-cycle valid strobe from the conversion core
module aafu_sample_select
  import aafu_pkg::*;
#(
  parameter int RES_W = `AAFU_RES_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             double_sample_enable,
  input  wire logic             res_valid,
  input  wire logic [RES_W-1:0] res,
  output aafu_sample_type       sample,
  output logic [RES_W-1:0]      prev
);
  logic             second_reg;
  logic [RES_W-1:0] prev_reg;
  logic [RES_W-1:0] prev_out_reg;

  // second conversion of a pair flags the cycle as complete
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_reg <= 1'b0;
    end else if (!double_sample_enable) begin
      second_reg <= 1'b0;
    end else if (res_valid) begin
      second_reg <= !second_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else if (res_valid) begin
      prev_reg <= res;
    end
  end

  always_comb begin
    sample = '0;
    if (!double_sample_enable) begin
      sample.valid     = res_valid;
      sample.magnitude = `AAFU_ACC_W'(res);
    end else begin
      sample.valid = res_valid && second_reg;
      if (res >= prev_reg) begin
        sample.magnitude = `AAFU_ACC_W'(res - prev_reg);
      end else begin
        sample.signed_neg = 1'b1;
        sample.magnitude  = `AAFU_ACC_W'(prev_reg - res);
      end
    end
  end

  // reported previous sample trails by one result, so after a pair it holds sample one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_out_reg <= '0;
    end else if (res_valid) begin
      prev_out_reg <= prev_reg;
    end
  end

  assign prev = prev_out_reg;
endmodule

//--- rtl/aafu_top.sv
// accumulate/filter unit: accumulator, sample counter, filtered value and threshold qualifier
// assumes conversion results arrive synchronous to MCLK, one cycle strobe each
module aafu_top
  import aafu_pkg::*;
#(
  parameter int ACC_W   = `AAFU_ACC_W,
  parameter int RES_W   = `AAFU_RES_W,
  parameter int CNT_W   = `AAFU_CNT_W,
  parameter int SHIFT_W = `AAFU_SHIFT_W
) (
  input  wire logic               MCLK,
  input  wire logic               RESET,
  input  wire logic [2:0]         COMPUTATION_MODE_SELECT,
  input  wire logic               DOUBLE_SAMPLE_ENABLE,
  input  wire logic [SHIFT_W-1:0] SHIFT_AMOUNT,
  input  wire logic [CNT_W-1:0]   REPEAT_TARGET,
  input  wire logic               ACCUMULATOR_CLEAR_SET,
  input  wire logic               START_TRIGGER,
  input  wire logic               CONVERSION_VALID,
  input  wire logic [RES_W-1:0]   CONVERSION_RESULT,
  output logic                    ACCUMULATOR_CLEAR_REQUEST,
  output logic [ACC_W-1:0]        ACCUMULATOR_VALUE,
  output logic [CNT_W-1:0]        SAMPLE_COUNTER,
  output logic                    ACCUMULATOR_OVERFLOW_FLAG,
  output logic [ACC_W-1:0]        FILTERED_RESULT,
  output logic [RES_W-1:0]        PREVIOUS_SAMPLE,
  output logic                    THRESHOLD_TEST_STROBE,
  output logic                    RETRIGGER
);
  aafu_sample_type        sample;
  logic [RES_W-1:0]       prev;
  logic                   clearing;
  logic                   clr_busy;
  aafu_mode_type          mode;
  logic [ACC_W-1:0]       acc_reg;
  logic [ACC_W-1:0]       acc_next;
  logic                   acc_carry;
  logic [CNT_W-1:0]       cnt_reg;
  logic                   ovf_reg;
  logic [ACC_W-1:0]       flt_reg;
  logic                   test_reg;
  logic                   retrig_reg;
  logic                   clr_req_reg;
  logic                   auto_clear;
  logic                   accumulating;
  logic                   at_target;
  logic [CNT_W:0]         cnt_after;
  logic [CNT_W-1:0]       cnt_next;
  logic                   ovf_next;
  logic                   test_next;
  logic                   retrig_next;

  // unknown codes fall back to basic mode
  function automatic aafu_mode_type decode_mode(input logic [2:0] code);
    case (code)
      `AAFU_MODE_ACCUM: decode_mode = AAFU_ACCUM;
      `AAFU_MODE_AVG:   decode_mode = AAFU_AVG;
      `AAFU_MODE_BURST: decode_mode = AAFU_BURST;
      `AAFU_MODE_LPF:   decode_mode = AAFU_LPF;
      default:          decode_mode = AAFU_BASIC;
    endcase
  endfunction

  assign mode = decode_mode(COMPUTATION_MODE_SELECT);

  aafu_sample_select #(
    .RES_W (RES_W)
  ) u_sel (
    .clk       (MCLK),
    .rst       (RESET),
    .double_sample_enable      (DOUBLE_SAMPLE_ENABLE),
    .res_valid (CONVERSION_VALID),
    .res       (CONVERSION_RESULT),
    .sample    (sample),
    .prev      (prev)
  );

  aafu_clear_seq u_clr (
    .clk      (MCLK),
    .rst      (RESET),
    .req_set  (ACCUMULATOR_CLEAR_SET | clr_req_reg),
    .clearing (clearing),
    .busy     (clr_busy)
  );

  assign at_target    = (cnt_reg >= REPEAT_TARGET);
  assign accumulating = sample.valid && (mode != AAFU_BASIC) && !clearing;

  // count after this sample, one bit wider so a saturated counter cannot wrap
  assign cnt_after = {1'b0, cnt_reg} + {{CNT_W{1'b0}}, 1'b1};

  // automatic clear at start trigger only, never at retrigger (average mode at target, burst mode)
  always_comb begin
    auto_clear = 1'b0;
    if (START_TRIGGER) begin
      if (mode == AAFU_AVG && at_target) begin
        auto_clear = 1'b1;
      end else if (mode == AAFU_BURST) begin
        auto_clear = 1'b1;
      end
    end
  end

  // next accumulator value with carry out for overflow
  always_comb begin
    logic [ACC_W:0] base;
    logic [ACC_W:0] sum;
    sum  = '0;
    base = {1'b0, acc_reg};
    if (mode == AAFU_LPF) begin
      base = {1'b0, acc_reg - (acc_reg >> SHIFT_AMOUNT)};
    end
    if (sample.signed_neg) begin
      sum = base - {1'b0, sample.magnitude};
    end else begin
      sum = base + {1'b0, sample.magnitude};
    end
    acc_next  = sum[ACC_W-1:0];
    acc_carry = sum[ACC_W];
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      acc_reg <= `AAFU_ACC_RST;
    end else if (clearing || auto_clear) begin
      acc_reg <= `AAFU_ACC_RST;
    end else if (accumulating) begin
      acc_reg <= acc_next;
    end
  end

  // clear first, then one step per accumulated sample, holding at saturation
  always_comb begin
    cnt_next = cnt_reg;
    if (clearing || auto_clear) begin
      cnt_next = `AAFU_CNT_RST;
    end else if (accumulating && cnt_reg != `AAFU_CNT_SAT) begin
      cnt_next = cnt_after[CNT_W-1:0];
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cnt_reg <= `AAFU_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // positive carry is overflow; a borrow on subtraction is not
  always_comb begin
    ovf_next = ovf_reg;
    if (clearing) begin
      ovf_next = 1'b0;
    end else if (accumulating && !auto_clear && acc_carry && !sample.signed_neg) begin
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      flt_reg <= `AAFU_ACC_RST;
    end else if (mode != AAFU_BASIC) begin
      flt_reg <= acc_reg >> SHIFT_AMOUNT;
    end
  end

  // threshold qualifier pulses at the port two cycles after a completed computation cycle
  always_comb begin
    test_next = 1'b0;
    if (!sample.valid || clearing || auto_clear) begin
      test_next = 1'b0;
    end else if (mode == AAFU_BASIC || mode == AAFU_ACCUM) begin
      test_next = 1'b1;
    end else begin
      test_next = (cnt_after >= {1'b0, REPEAT_TARGET}) || (cnt_reg == `AAFU_CNT_SAT);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      test_reg <= 1'b0;
    end else begin
      test_reg <= test_next;
    end
  end

  // burst mode asks for another conversion while below target
  always_comb begin
    retrig_next = 1'b0;
    if (mode == AAFU_BURST && accumulating && !auto_clear) begin
      retrig_next = (cnt_after < {1'b0, REPEAT_TARGET});
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      retrig_reg <= 1'b0;
    end else begin
      retrig_reg <= retrig_next;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      clr_req_reg <= 1'b0;
    end else begin
      clr_req_reg <= clr_busy && !(ACCUMULATOR_CLEAR_SET == 1'b0 && !clearing && clr_req_reg);
    end
  end

  // port copies, overflow flag masked to 0 in basic mode: every output leaves straight from its own flop
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ACCUMULATOR_CLEAR_REQUEST <= 1'b0;
    end else begin
      ACCUMULATOR_CLEAR_REQUEST <= clr_req_reg;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ACCUMULATOR_VALUE <= `AAFU_ACC_RST;
    end else begin
      ACCUMULATOR_VALUE <= acc_reg;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      SAMPLE_COUNTER <= `AAFU_CNT_RST;
    end else begin
      SAMPLE_COUNTER <= cnt_reg;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ACCUMULATOR_OVERFLOW_FLAG <= 1'b0;
    end else begin
      ACCUMULATOR_OVERFLOW_FLAG <= ovf_reg && (mode != AAFU_BASIC);
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      FILTERED_RESULT <= `AAFU_ACC_RST;
    end else begin
      FILTERED_RESULT <= flt_reg;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      PREVIOUS_SAMPLE <= '0;
    end else begin
      PREVIOUS_SAMPLE <= prev;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      THRESHOLD_TEST_STROBE <= 1'b0;
    end else begin
      THRESHOLD_TEST_STROBE <= test_reg;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RETRIGGER <= 1'b0;
    end else begin
      RETRIGGER <= retrig_reg;
    end
  end
endmodule
